// file: logic/aemr_consts.svh
// Constants of the asynchronous memory normal-mode read engine
`ifndef AEMR_CONSTS_SVH
`define AEMR_CONSTS_SVH
// Register byte offsets
`define AEMR_OFS_CFG 4'h0
`define AEMR_OFS_MSET 4'h4
`define AEMR_OFS_MCLR 4'h8
`define AEMR_OFS_STAT 4'hc
// Region config reset and writable bits
`define AEMR_CFG_RST 32'h0000_0000
`define AEMR_CFG_WMASK 32'h007f_ffff
// Mask bit positions
`define AEMR_MSK_TMO 0
`define AEMR_MSK_WR 1
// AXI responses
`define AEMR_RESP_OK 2'h0
`define AEMR_RESP_ERR 2'h2
// Timeout unit in cycles, last access index per word
`define AEMR_TMO_UNIT 9'h010
`define AEMR_BEATS8 2'h3
`define AEMR_BEATS16 2'h1
`endif

// file: logic/aemr_pkg.sv
// Types of the asynchronous memory normal-mode read engine
`default_nettype none
package aemr_pkg;
	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TURN = 3'b001,
		ST_SETUP = 3'b010,
		ST_STROBE = 3'b011,
		ST_HOLD = 3'b100
	} aemr_state_t;
	// Region configuration layout
	typedef struct packed {
		logic [8:0] rsvd;
		logic [3:0] max_wait;
		logic wait_pol;
		logic wait_en;
		logic sel_strobe;
		logic bus_w16;
		logic [1:0] ta;
		logic [2:0] hold;
		logic [5:0] strobe;
		logic [3:0] setup;
	} aemr_cfg_t;
	// Loaded period values
	typedef struct packed {
		logic [5:0] strobe;
		logic [2:0] hold;
		logic [3:0] setup;
	} aemr_times_t;
endpackage
`default_nettype wire

// file: logic/aemr_read.sv
// Normal-mode asynchronous memory read engine with AXI4-Lite registers
// Functional notes
// RULE1: mask clear bit one clears wait-rise mask
// RULE2: timeout mask clear blocks timeout interrupt
// RULE3: normal mode when select-strobe bit zero
// RULE4: byte enable outputs act as byte enables
// RULE5: write enable held high during reads
// RULE6: start read only when top priority
// RULE7: repeat access cycles until request complete
// RULE8: insert programmed turnaround cycles before setup
// RULE9: read after read has no turnaround
// RULE10: read after write, zero field, one cycle
// RULE11: recheck priority after turnaround, else abandon
// RULE12: load setup strobe hold at setup start
// RULE13: address valid, select low at setup
// RULE14: output enable falls at strobe start
// RULE15: strobe end raises enable, samples data
// RULE16: wait input stretches the strobe period
// RULE17: hold end drops address, maybe select
// RULE18: further cycles reenter setup, keep values
// RULE19: word done, return idle or next
// RULE20: width bit picks 8 or 16 bits
// RULE21: wait only when enabled, polarity programmable
// RULE22: setup strobe hold counted in order
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "aemr_consts.svh"
module aemr_read #(
	parameter int ADDR_W = 22
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// AXI4-Lite slave
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Read requester
	input wire logic req_valid,
	input wire logic req_top,
	input wire logic last_op_write,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic busy,
	// External memory pins
	output logic region_select_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic [1:0] byte_enable_out,
	output logic [ADDR_W-1:0] ext_address,
	output logic [1:0] ext_bank_address,
	input wire logic [15:0] ext_data_bus_in,
	output logic [15:0] ext_data_bus_out,
	output logic ext_data_bus_oe,
	input wire logic ext_wait_in,
	// Events to the interrupt unit
	output logic timeout_int,
	output logic [1:0] int_mask
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] cfg_q; // Region configuration
	logic [1:0] mask_q; // Interrupt mask bits
	aemr_pkg::aemr_cfg_t cfg; // Decoded configuration
	aemr_pkg::aemr_state_t state_q;
	aemr_pkg::aemr_times_t times_q; // Values loaded at setup
	logic [5:0] cnt_q; // Period counter
	logic [1:0] beat_q; // Access index in word
	logic [8:0] tmo_q; // Extended wait counter
	logic wait_s1_q, wait_s2_q; // Wait synchroniser
	logic [15:0] data_s1_q, data_s2_q; // Data bus synchroniser
	logic [31:0] acc_q; // Assembled word
	logic cs_n_q, oe_n_q, rd_valid_q, tmo_int_q;
	logic busy_q; // Select is active
	logic [ADDR_W-1:0] addr_q;
	logic [1:0] bank_q;
	logic wait_act, tmo_hit, last_beat, wr_go, req_go;
	logic [8:0] tmo_lim;
	logic [ADDR_W+1:0] lin_addr, nxt_addr; // First and next access address

	// Merge write data under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i+:8] = nw[8*i+:8];
			end
		end
		return r;
	endfunction

	// Address of one access: byte or halfword units
	function automatic logic [ADDR_W+1:0] beat_addr(
		input logic [ADDR_W-1:0] a, input logic [1:0] b,
		input logic w16);
		logic [ADDR_W+1:0] r;
		r = w16 ? {1'b0, a, b[0]} : {a, b};
		return r;
	endfunction

	assign cfg = aemr_pkg::aemr_cfg_t'(cfg_q);
	assign wr_go = !awready_q && !wready_q && !bvalid_q;
	// Wait is active at the programmed level, only when enabled
	assign wait_act = cfg.wait_en && (wait_s2_q == cfg.wait_pol); // RULE21
	assign tmo_lim = 9'({5'h0, cfg.max_wait} + 9'h1) * `AEMR_TMO_UNIT;
	assign tmo_hit = (tmo_q == tmo_lim);
	// Access count follows the bus width
	assign last_beat = cfg.bus_w16 ? (beat_q == `AEMR_BEATS16)
		: (beat_q == `AEMR_BEATS8); // RULE20
	// A new word always starts at access zero, whatever beat_q still holds
	assign lin_addr = beat_addr(req_addr, 2'h0, cfg.bus_w16);
	assign nxt_addr = beat_addr(req_addr, beat_q + 2'h1, cfg.bus_w16);
	// Completion pulse blocks a restart while the requester still holds
	assign req_go = req_valid && req_top && !cfg.sel_strobe && !rd_valid_q;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	// Take address and data in any order, answer after both
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `AEMR_RESP_OK;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			// Address taken
			if (s_awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q <= s_awaddr;
			end
			// Data taken
			if (s_wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			// Both held: respond
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr_q == `AEMR_OFS_STAT)
					? `AEMR_RESP_ERR : `AEMR_RESP_OK;
			end
			// Response accepted: reopen
			if (bvalid_q && s_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Register writes: configuration and mask set or clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= `AEMR_CFG_RST;
			mask_q <= 2'h0;
		end else if (wr_go) begin
			unique case (awaddr_q)
				`AEMR_OFS_CFG: begin
					cfg_q <= merge(cfg_q, wdata_q, wstrb_q)
						& `AEMR_CFG_WMASK;
				end
				`AEMR_OFS_MSET: begin
					if (wstrb_q[0]) begin
						mask_q <= mask_q | wdata_q[1:0];
					end
				end
				`AEMR_OFS_MCLR: begin
					// One clears timeout and wait-rise masks
					if (wstrb_q[0]) begin
						mask_q <= mask_q & ~wdata_q[1:0]; // RULE1 RULE2
					end
				end
				default: begin
					mask_q <= mask_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	// One read at a time, data one cycle after the address
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `AEMR_RESP_OK;
		end else if (s_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= `AEMR_RESP_OK;
			unique case (s_araddr)
				`AEMR_OFS_CFG: rdata_q <= cfg_q;
				`AEMR_OFS_MSET, `AEMR_OFS_MCLR: begin
					rdata_q <= {30'h0, mask_q};
				end
				`AEMR_OFS_STAT: begin
					rdata_q <= {27'h0, beat_q, state_q};
				end
				default: begin
					rdata_q <= 32'h0;
					rresp_q <= `AEMR_RESP_ERR;
				end
			endcase
		end else if (rvalid_q && s_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin input synchronisers

	// Two stages before any logic looks at wait or data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wait_s1_q <= 1'b0;
			wait_s2_q <= 1'b0;
			data_s1_q <= 16'h0;
			data_s2_q <= 16'h0;
		end else begin
			wait_s1_q <= ext_wait_in;
			wait_s2_q <= wait_s1_q;
			data_s1_q <= ext_data_bus_in;
			data_s2_q <= data_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Access sequencer

	// Turnaround, setup, strobe and hold in strict order
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= aemr_pkg::ST_IDLE;
			cnt_q <= 6'h0;
			beat_q <= 2'h0;
			times_q <= '0;
		end else begin
			unique case (state_q)
				aemr_pkg::ST_IDLE: begin
					// Normal mode request that is top priority
					if (req_go) begin // RULE3 RULE6
						beat_q <= 2'h0;
						times_q <= {cfg.strobe, cfg.hold, cfg.setup}; // RULE12
						cnt_q <= {2'h0, cfg.setup};
						if (!last_op_write) begin
							state_q <= aemr_pkg::ST_SETUP; // RULE9
						end else begin
							// Zero field still costs one cycle
							cnt_q <= (cfg.ta == 2'h0) ? 6'h1
								: {4'h0, cfg.ta}; // RULE8 RULE10
							state_q <= aemr_pkg::ST_TURN;
						end
					end
				end
				aemr_pkg::ST_TURN: begin
					if (cnt_q > 6'h1) begin
						cnt_q <= cnt_q - 6'h1;
					end else if (req_valid && req_top) begin
						// Still top priority: go to setup
						times_q <= {cfg.strobe, cfg.hold, cfg.setup}; // RULE12
						cnt_q <= {2'h0, cfg.setup};
						state_q <= aemr_pkg::ST_SETUP; // RULE11
					end else begin
						state_q <= aemr_pkg::ST_IDLE; // RULE11
					end
				end
				aemr_pkg::ST_SETUP: begin
					if (cnt_q != 6'h0) begin
						cnt_q <= cnt_q - 6'h1;
					end else begin
						cnt_q <= times_q.strobe;
						state_q <= aemr_pkg::ST_STROBE; // RULE22
					end
				end
				aemr_pkg::ST_STROBE: begin
					if (wait_act && !tmo_hit) begin
						cnt_q <= cnt_q; // RULE16
					end else if (cnt_q != 6'h0) begin
						cnt_q <= cnt_q - 6'h1;
					end else begin
						cnt_q <= {3'h0, times_q.hold};
						state_q <= aemr_pkg::ST_HOLD; // RULE22
					end
				end
				aemr_pkg::ST_HOLD: begin
					if (cnt_q != 6'h0) begin
						cnt_q <= cnt_q - 6'h1;
					end else if (!last_beat) begin
						// Next access: no turnaround, no reload
						beat_q <= beat_q + 2'h1; // RULE7
						cnt_q <= {2'h0, times_q.setup};
						state_q <= aemr_pkg::ST_SETUP; // RULE18
					end else begin
						state_q <= aemr_pkg::ST_IDLE; // RULE19
					end
				end
				default: begin
					state_q <= aemr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Extended wait counter and timeout event
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tmo_q <= 9'h0;
			tmo_int_q <= 1'b0;
		end else begin
			tmo_int_q <= 1'b0;
			if (state_q != aemr_pkg::ST_STROBE) begin
				tmo_q <= 9'h0;
			end else if (wait_act && !tmo_hit) begin
				tmo_q <= tmo_q + 9'h1;
				// Interrupt only while timeout mask is set
				tmo_int_q <= (tmo_q + 9'h1 == tmo_lim)
					&& mask_q[`AEMR_MSK_TMO]; // RULE2
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// External pin drivers

	// Select, enables and address follow the sequencer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cs_n_q <= 1'b1;
			busy_q <= 1'b0;
			oe_n_q <= 1'b1;
			addr_q <= '0;
			bank_q <= 2'h0;
		end else begin
			// Setup starts: address valid, select low
			if (state_q != aemr_pkg::ST_SETUP
				&& state_q != aemr_pkg::ST_STROBE
				&& state_q != aemr_pkg::ST_HOLD) begin
				if (state_q == aemr_pkg::ST_IDLE
					? (req_go && !last_op_write)
					: (cnt_q <= 6'h1 && req_valid && req_top)) begin
					cs_n_q <= 1'b0; // RULE13
					busy_q <= 1'b1;
					addr_q <= lin_addr[ADDR_W+1:2]; // RULE13
					bank_q <= lin_addr[1:0];
				end
			end
			// Strobe starts and ends
			if (state_q == aemr_pkg::ST_SETUP && cnt_q == 6'h0) begin
				oe_n_q <= 1'b0; // RULE14
			end
			if (state_q == aemr_pkg::ST_STROBE && cnt_q == 6'h0
				&& !(wait_act && !tmo_hit)) begin
				oe_n_q <= 1'b1; // RULE15
			end
			// Hold ends: address invalid, select up when done
			if (state_q == aemr_pkg::ST_HOLD && cnt_q == 6'h0) begin
				if (last_beat) begin
					cs_n_q <= 1'b1; // RULE17
					busy_q <= 1'b0;
					addr_q <= '0; // RULE17
					bank_q <= 2'h0;
				end else begin
					addr_q <= nxt_addr[ADDR_W+1:2]; // RULE18
					bank_q <= nxt_addr[1:0];
				end
			end
		end
	end

	// Data capture at strobe end and word completion
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			acc_q <= 32'h0;
			rd_data <= 32'h0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= 1'b0;
			if (state_q == aemr_pkg::ST_STROBE && cnt_q == 6'h0
				&& !(wait_act && !tmo_hit)) begin
				// Place the sampled lane by access index
				if (cfg.bus_w16) begin
					acc_q[16*beat_q[0]+:16] <= data_s2_q; // RULE15
				end else begin
					acc_q[8*beat_q+:8] <= data_s2_q[7:0]; // RULE15
				end
			end
			if (state_q == aemr_pkg::ST_HOLD && cnt_q == 6'h0
				&& last_beat) begin
				rd_data <= acc_q;
				rd_valid_q <= 1'b1; // RULE19
			end
		end
	end

	// Read-only pin levels: write enable fixed, byte enables follow select
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			write_enable_n <= 1'b1;
			byte_enable_out <= 2'h3;
		end else begin
			write_enable_n <= 1'b1; // RULE5
			// All lanes enabled, active low, one cycle behind select
			byte_enable_out <= cs_n_q ? 2'h3 : 2'h0; // RULE4
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_awready = awready_q;
	assign s_wready = wready_q;
	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;
	assign s_arready = arready_q;
	assign s_rvalid = rvalid_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;
	assign rd_valid = rd_valid_q;
	assign busy = busy_q;
	assign region_select_n = cs_n_q;
	assign output_enable_n = oe_n_q;
	assign ext_address = addr_q;
	assign ext_bank_address = bank_q;
	assign ext_data_bus_out = 16'h0;
	assign ext_data_bus_oe = 1'b0;
	assign timeout_int = tmo_int_q;
	assign int_mask = mask_q;

endmodule
`default_nettype wire

// file: sim/aemr_read_assertions.sv
// Concurrent checks on the read engine's memory side pins
`default_nettype none
module aemr_read_chk #(
	parameter int ADDR_W = 22
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Watched outputs
	input wire logic region_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [1:0] byte_enable_out,
	input wire logic [ADDR_W-1:0] ext_address,
	input wire logic [1:0] ext_bank_address,
	input wire logic ext_data_bus_oe,
	input wire logic rd_valid,
	input wire logic busy,
	input wire logic timeout_int,
	input wire logic [1:0] int_mask
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	we_high_a: assert property (write_enable_n)
		else $error("write enable low");
	bus_free_a: assert property (!ext_data_bus_oe)
		else $error("data bus driven");
	oe_sel_a: assert property (!output_enable_n |-> !region_select_n)
		else $error("enable low while idle");
	setup_first_a: assert property ($fell(region_select_n) |-> output_enable_n)
		else $error("no setup before strobe");
	be_on_a: assert property (!region_select_n && !$past(region_select_n)
		|-> byte_enable_out == 2'h0) else $error("byte enables off");
	be_off_a: assert property (region_select_n && $past(region_select_n)
		|-> byte_enable_out == 2'h3) else $error("byte enables on");
	addr_off_a: assert property (region_select_n |-> ext_address == '0
		&& ext_bank_address == 2'h0) else $error("address left valid");
	word_done_a: assert property ($rose(region_select_n) |-> rd_valid)
		else $error("no completion");
	done_pulse_a: assert property (rd_valid |=> !rd_valid)
		else $error("completion too long");
	oe_rise_a: assert property ($rose(output_enable_n) |-> !region_select_n)
		else $error("no hold after strobe");
	busy_sel_a: assert property (busy == !region_select_n)
		else $error("busy differs from select");
	tmo_masked_a: assert property (timeout_int |-> $past(int_mask[0]))
		else $error("timeout event while masked");
endmodule
bind aemr_read aemr_read_chk #(.ADDR_W(ADDR_W)) u_chk (.clock(clock),
	.rstn(rstn), .region_select_n(region_select_n),
	.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
	.byte_enable_out(byte_enable_out), .ext_address(ext_address),
	.ext_bank_address(ext_bank_address), .ext_data_bus_oe(ext_data_bus_oe),
	.rd_valid(rd_valid), .busy(busy), .timeout_int(timeout_int),
	.int_mask(int_mask));
`default_nettype wire

// file: sim/aemr_mem.sv
// Behavioural external memory answering normal-mode reads
`default_nettype none
module aemr_mem (
	// Clock
	input wire logic clock,
	// Memory pins
	input wire logic sel_n,
	input wire logic oe_n,
	input wire logic [21:0] addr,
	input wire logic [1:0] bank,
	output logic [15:0] dq,
	output logic wait_o,
	// Test controls
	input wire logic slow,
	input wire logic pol,
	input wire logic hang
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_q = 16'h0;
	logic [3:0] wcnt_q = 4'h0;
	logic [7:0] u;
	// Content is a function of the unit address
	assign u = {addr[5:0], bank};
	// Released bus toggles so a stale value never passes
	assign dq = (!sel_n && !oe_n) ? {~u, u} : ~last_q;
	always_ff @(posedge clock) last_q <= dq;
	// Cycles of the current strobe
	always_ff @(posedge clock) wcnt_q <= oe_n ? 4'h0 : wcnt_q + 4'h1;
	// Slow device stretches the strobe for six cycles, a hung one forever
	assign wait_o = (!oe_n && (hang || (slow && wcnt_q < 4'h6)))
		? pol : ~pol;
endmodule
`default_nettype wire

// file: sim/aemr_read_tb.sv
// Self-checking bench of the normal-mode read engine
`default_nettype none
module aemr_read_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0, rstn = 1'h0, s_awvalid = 1'h0, s_wvalid = 1'h0;
	logic s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0, slow = 1'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_wait_in;
	logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
	logic [31:0] s_wdata = '0, s_rdata, rd_data, v;
	logic [1:0] s_bresp, s_rresp, resp, byte_enable_out, ext_bank_address;
	logic [1:0] int_mask;
	logic req_valid = 1'h0, req_top = 1'h0, last_op_write = 1'h0;
	logic rd_valid, busy, region_select_n, output_enable_n, write_enable_n;
	logic ext_data_bus_oe, timeout_int;
	logic hang = 1'h0, mpol = 1'h1;
	int n_tmo = 0;
	logic [21:0] req_addr = '0, ext_address;
	logic [15:0] ext_data_bus_in;
	int n_mismatch = 0, comparisons = 0, cyc = 0, lat0, lat, dur;
	////////////////////////////////////////////////////////////////////////
	aemr_read #(.ADDR_W(22)) u_dut (.clock(clock), .rstn(rstn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .req_valid(req_valid),
		.req_top(req_top), .last_op_write(last_op_write),
		.req_addr(req_addr), .rd_valid(rd_valid), .rd_data(rd_data),
		.busy(busy), .region_select_n(region_select_n),
		.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
		.byte_enable_out(byte_enable_out), .ext_address(ext_address),
		.ext_bank_address(ext_bank_address), .ext_data_bus_out(),
		.ext_data_bus_in(ext_data_bus_in), .ext_data_bus_oe(ext_data_bus_oe),
		.ext_wait_in(ext_wait_in), .timeout_int(timeout_int),
		.int_mask(int_mask));
	aemr_mem u_mem (.clock(clock), .sel_n(region_select_n),
		.oe_n(output_enable_n), .addr(ext_address), .bank(ext_bank_address),
		.dq(ext_data_bus_in), .wait_o(ext_wait_in), .slow(slow), .pol(mpol),
		.hang(hang));
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #2.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	// Timeout event pulses seen
	always @(posedge clock) if (timeout_int === 1'h1) n_tmo <= n_tmo + 1;
	// Config word: setup 1, strobe 5, hold 1, polarity high
	function automatic logic [31:0] cf(input logic [1:0] t, input logic h,
		input logic s, input logic e);
		return {13'h0, 1'h1, e, s, h, t, 3'h1, 6'h5, 4'h1};
	endfunction
	// Word as the memory model's content lands in it
	function automatic logic [31:0] ew(input logic [21:0] w, input logic h);
		logic [31:0] r;
		logic [7:0] u;
		for (int k = 0; k < 4; k++) begin
			u = h ? {w[6:0], k[0]} : {w[5:0], k[1:0]};
			if (h && k < 2) r[16*k+:16] = {~u, u};
			else if (!h) r[8*k+:8] = u;
		end
		return r;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// AXI4-Lite write with both channels offered together
	task automatic wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_awready) s_awvalid <= 1'h0;
			if (s_wready) s_wvalid <= 1'h0;
		end while (s_bvalid !== 1'h1);
		resp = s_bresp;
		s_bready <= 1'h0;
	endtask
	// AXI4-Lite read
	task automatic rdr(input logic [3:0] a);
		@(posedge clock);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_arready) s_arvalid <= 1'h0;
		end while (s_rvalid !== 1'h1);
		v = s_rdata;
		resp = s_rresp;
		s_rready <= 1'h0;
	endtask
	// One word read; counts cycles before and during select
	task automatic rq(input logic [21:0] w, input logic lw);
		@(posedge clock);
		req_addr <= w;
		last_op_write <= lw;
		req_valid <= 1'h1;
		req_top <= 1'h1;
		lat = 0;
		dur = 0;
		do begin
			@(posedge clock);
			if (!region_select_n) dur++;
			else if (dur == 0) lat++;
		end while (rd_valid !== 1'h1 && lat < 500);
		req_valid <= 1'h0;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		rdr(4'h0); chk(v, '0);
		wrr(4'hc, '1); chk(resp, 2'h2);
		rdr(4'h2); chk(v, '0);
		chk(resp, 2'h2);
		wrr(4'h4, 32'h3); chk(int_mask, 2'h3);
		wrr(4'h8, 32'h2); chk(int_mask, 2'h1);
		rdr(4'h8); chk(v, 32'h1);
		wrr(4'h8, 32'h1); chk(int_mask, 2'h0);
		$display("registers and masks done");
		wrr(4'h0, cf(2'h0, 1'h1, 1'h0, 1'h0));
		rdr(4'h0); chk(v, cf(2'h0, 1'h1, 1'h0, 1'h0));
		rq(22'h25, 1'h0); lat0 = lat;
		chk(dur, 20);
		chk(rd_data, ew(22'h25, 1'h1));
		rq(22'h26, 1'h0); chk(lat, lat0);
		chk(rd_data, ew(22'h26, 1'h1));
		wrr(4'h0, cf(2'h0, 1'h0, 1'h0, 1'h0));
		rq(22'h13, 1'h0); chk(dur, 40);
		chk(rd_data, ew(22'h13, 1'h0));
		$display("widths done");
		for (int t = 0; t < 4; t++) begin
			wrr(4'h0, cf(t[1:0], 1'h1, 1'h0, 1'h0));
			rq(22'h31, 1'h1); chk(lat, lat0 + (t == 0 ? 1 : t));
		end
		@(posedge clock);
		req_valid <= 1'h1;
		req_top <= 1'h1;
		@(posedge clock);
		req_top <= 1'h0;
		dur = 0;
		repeat (12) @(posedge clock) if (!region_select_n) dur++;
		chk(dur, 0);
		rq(22'h0a, 1'h1); chk(rd_data, ew(22'h0a, 1'h1));
		$display("turnaround done");
		wrr(4'h0, cf(2'h0, 1'h1, 1'h0, 1'h1));
		slow <= 1'h1;
		rq(22'h17, 1'h0); chk(dur > 20, 1'h1);
		chk(rd_data, ew(22'h17, 1'h1));
		wrr(4'h0, cf(2'h0, 1'h1, 1'h0, 1'h0));
		rq(22'h18, 1'h0); chk(dur, 20);
		mpol <= 1'h0;
		wrr(4'h0, cf(2'h0, 1'h1, 1'h0, 1'h1) ^ 32'h0004_0000);
		rq(22'h19, 1'h0); chk(dur > 20, 1'h1);
		chk(rd_data, ew(22'h19, 1'h1));
		slow <= 1'h0;
		mpol <= 1'h1;
		wrr(4'h4, 32'h1); chk(int_mask, 2'h1);
		wrr(4'h0, cf(2'h0, 1'h1, 1'h0, 1'h1));
		hang <= 1'h1;
		rq(22'h1a, 1'h0); chk(n_tmo, 2);
		chk(rd_data, ew(22'h1a, 1'h1));
		wrr(4'h8, 32'h1); chk(int_mask, 2'h0);
		rq(22'h1b, 1'h0); chk(n_tmo, 2);
		chk(rd_data, ew(22'h1b, 1'h1));
		hang <= 1'h0;
		wrr(4'h0, cf(2'h0, 1'h1, 1'h1, 1'h0));
		@(posedge clock);
		req_valid <= 1'h1;
		dur = 0;
		repeat (10) @(posedge clock) if (busy !== 1'h0) dur++;
		req_valid <= 1'h0;
		chk(dur, 0);
		$display("wait and mode done");
		conclude();
	end
endmodule
`default_nettype wire
